// ===== cbc_pkg.sv
// constants, field layout and types for the converter boot-config register bank
package cbc_pkg;

   // ------------------------------------------------------------
   // bus geometry
   // ------------------------------------------------------------
   localparam int          ADR_W          = 17;
   localparam int          DAT_W          = 32;
   localparam int          IDX_W          = 15;
   localparam int          IDX_LSB        = 2;

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [14:0] PAIR_IDX       = 15'h7812;
   localparam logic [14:0] PHASE_IDX      = 15'h7813;
   localparam logic [14:0] CTRL_IDX       = 15'h7820;
   localparam logic [14:0] STAT_IDX       = 15'h7821;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int          SLOT4_LO       = 13;
   localparam int          VSEL4_LO       = 8;
   localparam int          SLOT3_LO       = 5;
   localparam int          VSEL3_LO       = 0;
   localparam int          INV_LO         = 12;
   localparam int          CAP4_LO        = 10;
   localparam int          CTRL_ON_BIT    = 0;
   localparam int          SLOT_W         = 3;
   localparam int          VSEL_W         = 5;
   localparam int          VCODE_W        = 7;
   localparam int          MV_W           = 12;
   localparam int          NCONV          = 4;
   localparam int          CAP_W          = 2;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] PAIR_RST       = 16'h0000;
   localparam logic [3:0]  INV_RST        = 4'h2;
   localparam logic [1:0]  CAP_RST        = 2'h0;

   // ------------------------------------------------------------
   // slot codes and voltage map
   // ------------------------------------------------------------
   localparam logic [2:0]  SLOT_OFF       = 3'h0;
   localparam logic [2:0]  SLOT_LAST      = 3'h5;
   localparam logic [2:0]  SLOT_HW1       = 3'h6;
   localparam logic [2:0]  SLOT_HW2       = 3'h7;
   localparam int          V_BASE_MV      = 850;
   localparam int          V_STEP_MV      = 25;
   localparam int          V_MAX_MV       = 3400;
   localparam logic [6:0]  V_SAT_CODE     = 7'h66;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          SLOT_TIME_US   = 2000;
   localparam int          SLOT_CYCLES    = SLOT_TIME_US * 1000 / CLK_PERIOD_NS;

   typedef enum logic [1:0] {CBC_IDLE, CBC_SAMPLE, CBC_RUN} cbc_state_t;

endpackage : cbc_pkg

// ===== cbc_seq_if.sv
// sequencer timing signals shared by the controller, slot timer and converters
`timescale 1ns/1ps
interface cbc_seq_if;
   logic       run;
   logic       sample;
   logic [2:0] slot;
   logic       done;

   modport ctrl  (output run, output sample, input slot, input done);
   modport timer (input run, output slot, output done);
   modport conv  (input run, input sample, input slot);
endinterface : cbc_seq_if

// ===== cbc_slot_timer.sv
// startup timeslot counter that steps to the next slot every SLOT_LEN clock cycles while run is high, stopping at SLOT_LAST
`timescale 1ns/1ps
module cbc_slot_timer
   import cbc_pkg::*;
#(
   parameter int SLOT_LEN = SLOT_CYCLES
)(
   input  wire logic sys_clk,
   input  wire logic resetn,
   cbc_seq_if.timer  seq
);
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic [2:0]  next_slot;
   logic        next_done;

   always_comb begin
      next_cnt  = cnt;
      next_slot = seq.slot;
      if (!seq.run) begin
         next_cnt  = '0;
         next_slot = SLOT_OFF;
      end else if (seq.slot != SLOT_LAST) begin
         if (cnt == 32'(SLOT_LEN - 1)) begin
            next_cnt  = '0;
            next_slot = seq.slot + 3'h1;
         end else begin
            next_cnt = cnt + 32'h1;
         end
      end
      next_done = (next_slot == SLOT_LAST);
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt      <= '0;
         seq.slot <= SLOT_OFF;
         seq.done <= 1'b0;
      end else begin
         cnt      <= next_cnt;
         seq.slot <= next_slot;
         seq.done <= next_done;
      end
   end
endmodule : cbc_slot_timer

// ===== cbc_conv_start.sv
// per-converter startup: samples slot and voltage, applies voltage, then enables
`timescale 1ns/1ps
module cbc_conv_start
   import cbc_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               resetn,
   cbc_seq_if.conv                 seq,
   input  wire logic [SLOT_W-1:0]  slot_code,
   input  wire logic [VSEL_W-1:0]  vsel,
   input  wire logic               hw_en1,
   input  wire logic               hw_en2,
   output logic      [SLOT_W-1:0]  held_slot,
   output logic      [VCODE_W-1:0] vcode,
   output logic      [MV_W-1:0]    mv,
   output logic                    en
);
   logic [SLOT_W-1:0]  next_held;
   logic [VCODE_W-1:0] next_vcode;
   logic [MV_W-1:0]    next_mv;
   logic               next_en;

   function automatic logic [MV_W-1:0] code_mv(input logic [VCODE_W-1:0] c);
      if (c >= V_SAT_CODE) begin
         return MV_W'(V_MAX_MV);
      end
      return MV_W'(V_BASE_MV + int'(c) * V_STEP_MV);
   endfunction : code_mv

   always_comb begin
      next_held  = held_slot;
      next_vcode = vcode;
      next_mv    = mv;
      next_en    = en;
      if (seq.sample) begin
         next_held  = slot_code;
         next_vcode = {vsel, 2'b00};
         next_mv    = code_mv({vsel, 2'b00});
      end
      if (!seq.run || seq.sample) begin
         next_en = 1'b0;
      end else begin
         case (held_slot)
            SLOT_OFF: next_en = 1'b0;
            SLOT_HW1: next_en = hw_en1;
            SLOT_HW2: next_en = hw_en2;
            default:  next_en = en | (seq.slot >= held_slot);
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         held_slot <= SLOT_OFF;
         vcode     <= '0;
         mv        <= MV_W'(V_BASE_MV);
         en        <= 1'b0;
      end else begin
         held_slot <= next_held;
         vcode     <= next_vcode;
         mv        <= next_mv;
         en        <= next_en;
      end
   end

   volt_map_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      seq.sample |=> mv == (({$past(vsel), 2'b00} >= V_SAT_CODE) ? MV_W'(V_MAX_MV)
                           : MV_W'(V_BASE_MV + int'({$past(vsel), 2'b00}) * V_STEP_MV)))
      else $error("voltage code maps to wrong level");
   slot_order_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(en) && held_slot <= SLOT_LAST |-> $past(seq.slot) >= held_slot && held_slot != SLOT_OFF)
      else $error("converter enabled before its timeslot");
   off_code_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      held_slot == SLOT_OFF && $past(held_slot) == SLOT_OFF |-> !en)
      else $error("disabled converter was enabled");
endmodule : cbc_conv_start

// ===== cbc_boot_regs.sv
// converter boot-config register bank with Wishbone slave and bootstrap sequencer
// Operation
// - converter four startup slot is 3 bits at 15:13 of first register, reset zero
// - converter three startup slot is 3 bits at 7:5 of first register, reset zero
// - slot 0 disables, 1..5 are timeslots, 6 and 7 follow hardware enables
// - converter four keeps upper five voltage bits at 12:8, 100 mV steps, reset zero
// - converter three keeps upper five voltage bits at 4:0, 0.85 to 3.4 V
// - voltage code 00h is 0.85 V, linear 25 mV, 66h upward saturates at 3.4 V
// - clock invert bits for converters four to one sit at bits 15..12
// - converter two clock invert resets to one, the others reset to zero
// - converter four capacitor range is 2 bits at 11:10, reset 00
// - capacitor range changes only through configuration loading, else read-only
`timescale 1ns/1ps
module cbc_boot_regs
   import cbc_pkg::*;
#(
   parameter int SLOT_LEN = SLOT_CYCLES
)(
   input  wire logic               sys_clk,
   input  wire logic               resetn,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [ADR_W-1:0]   wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [DAT_W-1:0]   wb_dat_i,
   output logic      [DAT_W-1:0]   wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic               cfg_load,
   input  wire logic [IDX_W-1:0]   cfg_load_idx,
   input  wire logic [15:0]        cfg_load_data,
   input  wire logic               power_on_pin,
   input  wire logic               hw_enable1_pin,
   input  wire logic               hw_enable2_pin,
   output logic                    conv3_enable,
   output logic                    conv4_enable,
   output logic      [VCODE_W-1:0] conv3_vcode,
   output logic      [VCODE_W-1:0] conv4_vcode,
   output logic      [MV_W-1:0]    conv3_mv,
   output logic      [MV_W-1:0]    conv4_mv,
   output logic      [NCONV-1:0]   conv_clk_invert,
   output logic      [CAP_W-1:0]   conv4_cap_range
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
      end else begin
         pin_meta <= {hw_enable2_pin, hw_enable1_pin, power_on_pin};
         pin_sync <= pin_meta;
      end
   end

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   logic [15:0]      pair_cfg;
   logic [15:0]      next_pair_cfg;
   logic [NCONV-1:0] next_invert;
   logic [CAP_W-1:0] next_cap;
   logic             ctrl_on;
   logic             next_ctrl_on;
   logic             wr_seen;
   logic             next_wr_seen;

   logic             bus_req;
   logic             bus_wr;
   logic [IDX_W-1:0] bus_idx;
   logic             wr_pair;
   logic             wr_phase;
   logic             wr_ctrl;
   logic             load_pair;
   logic             load_phase;

   assign bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr     = bus_req & wb_we_i;
   assign bus_idx    = wb_adr_i[ADR_W-1:IDX_LSB];
   assign wr_pair    = bus_wr & (bus_idx == PAIR_IDX);
   assign wr_phase   = bus_wr & (bus_idx == PHASE_IDX);
   assign wr_ctrl    = bus_wr & (bus_idx == CTRL_IDX);
   assign load_pair  = cfg_load & (cfg_load_idx == PAIR_IDX);
   assign load_phase = cfg_load & (cfg_load_idx == PHASE_IDX);

   // loading wins over a software write in the same cycle
   always_comb begin
      next_pair_cfg = pair_cfg;
      next_invert   = conv_clk_invert;
      next_cap      = conv4_cap_range;
      next_ctrl_on  = ctrl_on;
      next_wr_seen  = wr_seen | wr_pair | wr_phase | cfg_load;
      if (load_pair) begin
         next_pair_cfg = cfg_load_data;
      end else if (wr_pair) begin
         if (wb_sel_i[0]) begin
            next_pair_cfg[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            next_pair_cfg[15:8] = wb_dat_i[15:8];
         end
      end
      if (load_phase) begin
         next_invert = cfg_load_data[INV_LO +: NCONV];
         next_cap    = cfg_load_data[CAP4_LO +: CAP_W];
      end else if (wr_phase && wb_sel_i[1]) begin
         next_invert = wb_dat_i[INV_LO +: NCONV];
      end
      if (wr_ctrl && wb_sel_i[0]) begin
         next_ctrl_on = wb_dat_i[CTRL_ON_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pair_cfg        <= PAIR_RST;
         conv_clk_invert <= INV_RST;
         conv4_cap_range <= CAP_RST;
         ctrl_on         <= 1'b0;
         wr_seen         <= 1'b0;
      end else begin
         pair_cfg        <= next_pair_cfg;
         conv_clk_invert <= next_invert;
         conv4_cap_range <= next_cap;
         ctrl_on         <= next_ctrl_on;
         wr_seen         <= next_wr_seen;
      end
   end

   // ------------------------------------------------------------
   // field views
   // ------------------------------------------------------------
   logic [SLOT_W-1:0] conv4_start_slot;
   logic [VSEL_W-1:0] conv4_start_voltage;
   logic [SLOT_W-1:0] conv3_start_slot;
   logic [VSEL_W-1:0] conv3_start_voltage;

   assign conv4_start_slot    = pair_cfg[SLOT4_LO +: SLOT_W];
   assign conv4_start_voltage = pair_cfg[VSEL4_LO +: VSEL_W];
   assign conv3_start_slot    = pair_cfg[SLOT3_LO +: SLOT_W];
   assign conv3_start_voltage = pair_cfg[VSEL3_LO +: VSEL_W];

   // ------------------------------------------------------------
   // bootstrap sequencer
   // ------------------------------------------------------------
   cbc_seq_if  seq ();
   cbc_state_t state;
   cbc_state_t next_state;
   logic       on_level;
   logic       on_prev;
   logic       on_rise;
   logic       next_run;
   logic       next_sample;
   logic [SLOT_W-1:0] held3;
   logic [SLOT_W-1:0] held4;

   assign on_level = pin_sync[0] | ctrl_on;
   assign on_rise  = on_level & ~on_prev;

   // off wins over everything: dropping the request clears run on the next cycle and the enables one cycle after that
   always_comb begin
      next_state  = state;
      next_run    = 1'b0;
      next_sample = 1'b0;
      case (state)
         CBC_IDLE: begin
            if (on_rise) begin
               next_state  = CBC_SAMPLE;
               next_sample = 1'b1;
            end
         end
         CBC_SAMPLE: begin
            next_state = on_level ? CBC_RUN : CBC_IDLE;
            next_run   = on_level;
         end
         CBC_RUN: begin
            next_run = on_level;
            if (!on_level) begin
               next_state = CBC_IDLE;
            end
         end
         default: next_state = CBC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state      <= CBC_IDLE;
         on_prev    <= 1'b0;
         seq.run    <= 1'b0;
         seq.sample <= 1'b0;
      end else begin
         state      <= next_state;
         on_prev    <= on_level;
         seq.run    <= next_run;
         seq.sample <= next_sample;
      end
   end

   cbc_slot_timer #(
      .SLOT_LEN (SLOT_LEN)
   ) u_timer (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .seq     (seq.timer)
   );

   cbc_conv_start u_conv3 (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .seq       (seq.conv),
      .slot_code (conv3_start_slot),
      .vsel      (conv3_start_voltage),
      .hw_en1    (pin_sync[1]),
      .hw_en2    (pin_sync[2]),
      .held_slot (held3),
      .vcode     (conv3_vcode),
      .mv        (conv3_mv),
      .en        (conv3_enable)
   );

   cbc_conv_start u_conv4 (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .seq       (seq.conv),
      .slot_code (conv4_start_slot),
      .vsel      (conv4_start_voltage),
      .hw_en1    (pin_sync[1]),
      .hw_en2    (pin_sync[2]),
      .held_slot (held4),
      .vcode     (conv4_vcode),
      .mv        (conv4_mv),
      .en        (conv4_enable)
   );

   // ------------------------------------------------------------
   // wishbone answer
   // ------------------------------------------------------------
   logic [DAT_W-1:0] rd_mux;
   logic [DAT_W-1:0] next_dat;
   logic             next_ack;

   // unmapped addresses still ack, reading zero, so the bus never hangs
   always_comb begin
      rd_mux = '0;
      case (bus_idx)
         PAIR_IDX:  rd_mux[15:0] = pair_cfg;
         PHASE_IDX: rd_mux[15:0] = {conv_clk_invert, conv4_cap_range, 10'h000};
         CTRL_IDX:  rd_mux[CTRL_ON_BIT] = ctrl_on;
         STAT_IDX:  rd_mux[15:0] = {conv4_enable, conv3_enable, seq.done, seq.slot,
                                    held4, held3, 1'b0, on_level, state};
         default:   rd_mux = '0;
      endcase
      next_ack = bus_req;
      next_dat = (bus_req && !wb_we_i) ? rd_mux : '0;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence start_seq;
      state == CBC_SAMPLE ##1 seq.run;
   endsequence

   slot4_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      wr_pair && wb_sel_i[1] && !load_pair |=> conv4_start_slot == $past(wb_dat_i[15:13]))
      else $error("slot four field not written");
   slot3_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      wr_pair && wb_sel_i[0] && !load_pair |=> conv3_start_slot == $past(wb_dat_i[7:5]))
      else $error("slot three field not written");
   vsel4_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      wr_pair && wb_sel_i[1] && !load_pair |=> conv4_start_voltage == $past(wb_dat_i[12:8]))
      else $error("voltage four field not written");
   vsel3_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      wr_pair && wb_sel_i[0] && !load_pair |=> conv3_start_voltage == $past(wb_dat_i[4:0]))
      else $error("voltage three field not written");
   phase_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      wr_phase && wb_sel_i[1] && !load_phase |=> conv_clk_invert == $past(wb_dat_i[15:12]))
      else $error("clock invert bits not written");
   phase_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !wr_seen |-> conv_clk_invert == INV_RST && pair_cfg == PAIR_RST)
      else $error("wrong reset value");
   cap_readonly_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !load_phase |=> $stable(conv4_cap_range))
      else $error("capacitor range changed without loading");
   cap_load_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      load_phase |=> conv4_cap_range == $past(cfg_load_data[11:10]))
      else $error("capacitor range not loaded");
   boot_start_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      state == CBC_IDLE && on_rise ##1 on_level |-> seq.sample ##0 start_seq)
      else $error("power-on did not sample and start");

   // ------------------------------------------------------------
   // bus answer and sequencer checks
   // ------------------------------------------------------------
   sequence ack_once_seq;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   ack_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      bus_req |=> ack_once_seq)
      else $error("request not answered by one ack");
   rd_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !wb_ack_o |-> wb_dat_o == '0)
      else $error("read data outside an ack");
   ctrl_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      wr_ctrl && wb_sel_i[0] |=> ctrl_on == $past(wb_dat_i[CTRL_ON_BIT]))
      else $error("power-on request bit not written");

   pair_load_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      load_pair |=> pair_cfg == $past(cfg_load_data))
      else $error("first register not loaded");
   slot_take_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      seq.sample |=> held3 == $past(conv3_start_slot) && held4 == $past(conv4_start_slot))
      else $error("slot codes not sampled");
   code_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !seq.sample |=> $stable(conv3_vcode) && $stable(conv4_vcode) && $stable(conv3_mv))
      else $error("voltage changed outside sampling");

   hw_follow_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      held4 == SLOT_HW1 && seq.run && !seq.sample |=> conv4_enable == $past(pin_sync[1]))
      else $error("hardware enable not followed");
   off_drop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !on_level |-> ##2 (!conv3_enable && !conv4_enable))
      else $error("enable kept after power-on dropped");
   done_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      seq.done == (seq.slot == SLOT_LAST))
      else $error("last timeslot flag wrong");

endmodule : cbc_boot_regs

// ===== cbc_boot_regs_tb.sv
// self-checking testbench for the converter boot-config register bank
`timescale 1ns/1ps
module cbc_boot_regs_tb;
   import cbc_pkg::*;

   // ------------------------------------------------------------
   // signals and dut
   // ------------------------------------------------------------
   localparam int          SLEN   = 8;
   localparam logic [16:0] A_PAIR = {PAIR_IDX, 2'b00};
   localparam logic [16:0] A_PH   = {PHASE_IDX, 2'b00};
   localparam logic [16:0] A_CTRL = {CTRL_IDX, 2'b00};
   logic               sys_clk, resetn, cyc, stb, we, cfg_load, pwr, hw1, hw2;
   logic [ADR_W-1:0]   adr;
   logic [3:0]         sel;
   logic [DAT_W-1:0]   dat, wb_dat_o, rd;
   logic               wb_ack_o, conv3_enable, conv4_enable;
   logic [IDX_W-1:0]   cfg_load_idx;
   logic [15:0]        cfg_load_data;
   logic [VCODE_W-1:0] conv3_vcode, conv4_vcode;
   logic [MV_W-1:0]    conv3_mv, conv4_mv;
   logic [NCONV-1:0]   conv_clk_invert;
   logic [CAP_W-1:0]   conv4_cap_range;
   int                 failures, num_checks, n;

   cbc_boot_regs #(.SLOT_LEN(SLEN)) dut (
      .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .cfg_load(cfg_load), .cfg_load_idx(cfg_load_idx), .cfg_load_data(cfg_load_data),
      .power_on_pin(pwr), .hw_enable1_pin(hw1), .hw_enable2_pin(hw2),
      .conv3_enable(conv3_enable), .conv4_enable(conv4_enable), .conv3_vcode(conv3_vcode),
      .conv4_vcode(conv4_vcode), .conv3_mv(conv3_mv), .conv4_mv(conv4_mv),
      .conv_clk_invert(conv_clk_invert), .conv4_cap_range(conv4_cap_range));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   // holds the request until ack is sampled high, then releases for a cycle
   task automatic wb_xfer(input logic w, input logic [16:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [31:0] r);
      int k;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (k >= 50) begin
         failures++;
         stop_test();
      end
      r = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb_xfer

   task automatic wb_write(input logic [16:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      wb_xfer(1'b1, a, d, s, r);
   endtask : wb_write

   task automatic wb_read(input logic [16:0] a, output logic [31:0] r);
      wb_xfer(1'b0, a, 32'h0, 4'hF, r);
   endtask : wb_read

   task automatic load(input logic [14:0] i, input logic [15:0] d);
      @(posedge sys_clk);
      cfg_load      <= 1'b1;
      cfg_load_idx  <= i;
      cfg_load_data <= d;
      @(posedge sys_clk);
      cfg_load <= 1'b0;
   endtask : load

   // saturates at the top of the range instead of extending the line
   function automatic logic [31:0] exp_mv(input logic [4:0] v);
      logic [6:0] c;
      c = {v, 2'b00};
      exp_mv = (c >= V_SAT_CODE) ? 32'(V_MAX_MV) : 32'(V_BASE_MV + V_STEP_MV * c);
   endfunction : exp_mv

   // ------------------------------------------------------------
   // clock, watchdog and tests
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      stop_test();
   end

   initial begin
      resetn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; dat = '0;
      cfg_load = 1'b0; cfg_load_idx = '0; cfg_load_data = '0; pwr = 1'b0; hw1 = 1'b0; hw2 = 1'b0;
      failures = 0; num_checks = 0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      wb_read(A_PAIR, rd);
      chk("pair reset", 32'h0, rd);
      wb_read(A_PH, rd);
      chk("phase reset", 32'h2000, rd);
      chk("invert pins", 32'h2, conv_clk_invert);
      chk("mv reset", 32'(V_BASE_MV), conv3_mv);
      $display("test reset done");
      wb_write(A_PAIR, 32'hFFFF, 4'h3);
      wb_write(A_PAIR, 32'h0000, 4'h1);
      wb_read(A_PAIR, rd);
      chk("pair lanes", 32'hFF00, rd);
      wb_read(17'h00100, rd);
      chk("unmapped", 32'h0, rd);
      wb_write(A_PH, 32'hFC00, 4'h3);
      wb_read(A_PH, rd);
      chk("phase bus", 32'hF000, rd);
      chk("cap bus", 32'h0, conv4_cap_range);
      load(PHASE_IDX, 16'h5C00);
      wb_read(A_PH, rd);
      chk("phase load", 32'h5C00, rd);
      chk("cap load", 32'h3, conv4_cap_range);
      chk("invert load", 32'h5, conv_clk_invert);
      $display("test registers done");
      // conv4 follows hw enable 1, conv3 in timeslot 2
      wb_write(A_PAIR, 32'hD95F, 4'h3);
      wb_read(A_PAIR, rd);
      chk("pair rw", 32'hD95F, rd);
      @(posedge sys_clk);
      pwr <= 1'b1;
      for (n = 0; n < 30 && conv3_mv !== exp_mv(5'h1F); n++) @(posedge sys_clk);
      chk("conv3 mv", exp_mv(5'h1F), conv3_mv);
      chk("conv3 code", 32'h7C, conv3_vcode);
      chk("conv4 mv", 32'd3350, conv4_mv);
      chk("conv4 code", 32'h64, conv4_vcode);
      chk("conv3 early", 32'h0, conv3_enable);
      wb_write(A_PAIR, 32'h0000, 4'h3);
      for (n = 0; n < 60 && conv3_enable !== 1'b1; n++) @(posedge sys_clk);
      chk("slot2 late", 32'h1, 32'(n >= SLEN));
      chk("conv3 on", 32'h1, conv3_enable);
      chk("conv4 wait", 32'h0, conv4_enable);
      hw1 <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("conv4 hw1", 32'h1, conv4_enable);
      hw1 <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("conv4 hw1 off", 32'h0, conv4_enable);
      chk("mv kept", exp_mv(5'h1F), conv3_mv);
      pwr <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("conv3 off", 32'h0, conv3_enable);
      $display("test sequence one done");
      // conv4 code 0 never on, conv3 follows hw enable 2
      wb_write(A_PAIR, 32'h00E0, 4'h3);
      hw2 <= 1'b1;
      pwr <= 1'b1;
      repeat (6 * SLEN + 10) @(posedge sys_clk);
      chk("conv3 hw2", 32'h1, conv3_enable);
      chk("conv4 off", 32'h0, conv4_enable);
      chk("conv3 mv0", 32'(V_BASE_MV), conv3_mv);
      hw2 <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("conv3 hw2 off", 32'h0, conv3_enable);
      pwr <= 1'b0;
      $display("test sequence two done");
      // both converters in timeslot 1, started by the software request bit
      load(PAIR_IDX, 16'h2020);
      wb_read(A_PAIR, rd);
      chk("pair load", 32'h2020, rd);
      wb_write(A_CTRL, 32'h1, 4'h1);
      wb_read(A_CTRL, rd);
      chk("ctrl rw", 32'h1, rd);
      for (n = 0; n < 40 && conv4_enable !== 1'b1; n++) @(posedge sys_clk);
      chk("slot1 both", 32'h3, {conv4_enable, conv3_enable});
      wb_write(A_CTRL, 32'h0, 4'h1);
      repeat (4) @(posedge sys_clk);
      chk("ctrl off", 32'h0, {conv4_enable, conv3_enable});
      $display("test control done");
      stop_test();
   end
endmodule : cbc_boot_regs_tb
